/* File: src/pei_top.sv */
// Preempt entry logic: yellow-to-green revert, interlock monitor, fault flash sequence.
//
// Overview of operation
// - Yellow phase reverts to green when enabled.
// - Option off: yellow proceeds through red revert.
// - Yellow-to-green and terminate-all never both set.
// - Lagging overlap green suppresses yellow-to-green revert.
// - Non-opposite inputs for one second cause flash.
// - Preempts 1 and 2 share interlock one.
// - Disabled interlock input is ignored entirely.
// - Wait three seconds of stability before checking.
// - Idle 1/2: force both, all red, flash.
// - Preemptor 1 past track: all red, flash.
// - Preemptor 2 past track, 1 unprogrammed: direct.
// - Preemptor 2 past track, 1 programmed: force.
// - Terminating: restart timing, force both, flash.
// - Status output off, solid or three rates.
`timescale 1ns/1ps
module pei_top import pei_pkg::*; #(
    parameter int SETTLE_C = SETTLE_CYC,
    parameter int FAULT_C = FAULT_CYC,
    parameter int SLOW_C = SLOW_HALF_CYC,
    parameter int MED_C = MED_HALF_CYC,
    parameter int FAST_C = FAST_HALF_CYC
) (
    input wire logic clk, // 40 MHz system clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic [ADDR_W-1:0] awaddr, // AXI write address.
    input wire logic awvalid, // AXI write address valid.
    output logic awready, // AXI write address ready.
    input wire logic [31:0] wdata, // AXI write data.
    input wire logic [3:0] wstrb, // AXI write strobes.
    input wire logic wvalid, // AXI write data valid.
    output logic wready, // AXI write data ready.
    output logic [1:0] bresp, // AXI write response.
    output logic bvalid, // AXI write response valid.
    input wire logic bready, // AXI write response ready.
    input wire logic [ADDR_W-1:0] araddr, // AXI read address.
    input wire logic arvalid, // AXI read address valid.
    output logic arready, // AXI read address ready.
    output logic [31:0] rdata, // AXI read data.
    output logic [1:0] rresp, // AXI read response.
    output logic rvalid, // AXI read data valid.
    input wire logic rready, // AXI read data ready.
    input wire logic [NUM_PRE-1:0] preemptIn, // Hard-wired preempt inputs, high when active.
    input wire logic [NUM_PRE-1:0] interlockIn, // Hard-wired interlock inputs, high when true.
    input wire logic [NUM_PRE-1:0] preemptActive, // Sequencer: preemptor is active.
    input wire logic [NUM_PRE-1:0] preemptTerm, // Sequencer: preemptor terminating or leaving flash.
    input wire logic [1:0] trackClrTiming, // Sequencer: preemptor 1/2 timing track clearance.
    input wire logic [1:0] trackClrDone, // Sequencer: preemptor 1/2 track clearance ended.
    input wire logic allRedDone, // Sequencer: all-red clearance reached.
    input wire logic entryCall, // Sequencer: preemption call taken, one cycle.
    input wire logic [3:0] entryPlan, // Plan number of that call, zero based.
    input wire logic [NUM_PHASE-1:0] yellowPhases, // Phases timing yellow clearance.
    input wire logic [NUM_PHASE-1:0] nextGreenPhases, // Phases whose green times next in preemption.
    input wire logic lagOvlpGreen, // Lagging overlap green started on the way to preemption.
    output logic [NUM_PHASE-1:0] yellowToGreen, // Phases told to return straight to green.
    output logic [NUM_PHASE-1:0] redRevert, // Phases told to continue through red revert.
    output logic [1:0] forcePreempt, // Force preemptors 1 and 2 active.
    output logic [1:0] restartPreempt, // Restart preemptor 1/2 timing, one cycle.
    output logic allRedReq, // Request clear to all red.
    output logic faultMonOk, // Voltage/fault monitor, low forces latched flash.
    output logic [NUM_PRE-1:0] activeStatus, // Preemptor active status outputs.
    output logic irq // Interrupt, high while an unmasked event is pending.
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [NUM_PRE-1:0] preMetaQ;
    logic [NUM_PRE-1:0] preSyncQ;
    logic [NUM_PRE-1:0] ilkMetaQ;
    logic [NUM_PRE-1:0] ilkSyncQ;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            preMetaQ <= '0;
            preSyncQ <= '0;
            ilkMetaQ <= '0;
            ilkSyncQ <= '0;
        end else begin
            preMetaQ <= preemptIn;
            preSyncQ <= preMetaQ;
            ilkMetaQ <= interlockIn;
            ilkSyncQ <= ilkMetaQ;
        end
    end

    // ----------------------------------------------------------------
    // Registers and bus decode
    // ----------------------------------------------------------------
    logic [NUM_PRE-1:0] ilkEnQ;
    logic [NUM_PRE-1:0] progQ;
    logic [NUM_PRE-1:0] y2gEnQ;
    logic [NUM_PRE-1:0] termAllQ;
    logic [NUM_PRE*MODE_W-1:0] modeQ;
    logic [NUM_EVT-1:0] intStQ;
    logic [NUM_EVT-1:0] intMaskQ;
    logic [NUM_PRE-1:0] tripVec;
    logic [NUM_EVT-1:0] evt;
    pei_flt_state_t stateQ;
    pei_flt_state_t stateD;
    logic viaForceQ;

    wire logic wrGo = awvalid && wvalid && !bvalid;
    wire logic rdGo = arvalid && !rvalid;
    wire logic [31:0] wMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire logic wIlk = wrGo && (awaddr == OFF_ILK_EN);
    wire logic wProg = wrGo && (awaddr == OFF_PROG);
    wire logic wY2g = wrGo && (awaddr == OFF_Y2G);
    wire logic wTerm = wrGo && (awaddr == OFF_TERM_ALL);
    wire logic wMode = wrGo && (awaddr == OFF_MODE);
    wire logic wIst = wrGo && (awaddr == OFF_INT_STAT);
    wire logic wImask = wrGo && (awaddr == OFF_INT_MASK);
    wire logic wLatch = wrGo && (awaddr == OFF_LATCH_CLR);
    wire logic wHit = wIlk || wProg || wY2g || wTerm || wMode || wIst || wImask || wLatch
        || (awaddr == OFF_FAULT);
    wire logic [31:0] wMerge = wdata & wMask;
    wire logic [NUM_PRE-1:0] y2gNew = (y2gEnQ & ~wMask[NUM_PRE-1:0]) | wMerge[NUM_PRE-1:0];
    wire logic [NUM_PRE-1:0] termNew = (termAllQ & ~wMask[NUM_PRE-1:0]) | wMerge[NUM_PRE-1:0];
    // A plan may not hold both options; the bit that would collide is dropped.
    wire logic [NUM_PRE-1:0] y2gRefused = wY2g ? (y2gNew & termAllQ) : '0;
    wire logic [NUM_PRE-1:0] termRefused = wTerm ? (termNew & y2gEnQ) : '0;
    wire logic latchClr = wLatch && wMerge[0];
    wire logic [NUM_EVT-1:0] istClr = wIst ? wMerge[NUM_EVT-1:0] : '0;
    wire logic [31:0] faultWord = (32'(tripVec) << FLT_TRIP_LSB)
        | (32'(stateQ == FLT_LATCHED) << FLT_LATCH_BIT)
        | (32'(allRedReq) << FLT_ALLRED_BIT) | (32'(viaForceQ) << FLT_FORCE_BIT);
    wire logic [31:0] rdMux =
        (araddr == OFF_ILK_EN) ? 32'(ilkEnQ) :
        (araddr == OFF_PROG) ? 32'(progQ) :
        (araddr == OFF_Y2G) ? 32'(y2gEnQ) :
        (araddr == OFF_TERM_ALL) ? 32'(termAllQ) :
        (araddr == OFF_MODE) ? 32'(modeQ) :
        (araddr == OFF_INT_STAT) ? 32'(intStQ) :
        (araddr == OFF_INT_MASK) ? 32'(intMaskQ) :
        (araddr == OFF_FAULT) ? faultWord : RST_CFG;
    wire logic rHit = (araddr == OFF_ILK_EN) || (araddr == OFF_PROG) || (araddr == OFF_Y2G)
        || (araddr == OFF_TERM_ALL) || (araddr == OFF_MODE) || (araddr == OFF_INT_STAT)
        || (araddr == OFF_INT_MASK) || (araddr == OFF_FAULT) || (araddr == OFF_LATCH_CLR);

    assign awready = wrGo;
    assign wready = wrGo;
    assign arready = rdGo;
    assign irq = |(intStQ & intMaskQ);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ilkEnQ <= RST_CFG[NUM_PRE-1:0];
            progQ <= RST_CFG[NUM_PRE-1:0];
            y2gEnQ <= RST_CFG[NUM_PRE-1:0];
            termAllQ <= RST_CFG[NUM_PRE-1:0];
            modeQ <= RST_CFG[NUM_PRE*MODE_W-1:0];
            intStQ <= RST_CFG[NUM_EVT-1:0];
            intMaskQ <= RST_CFG[NUM_EVT-1:0];
        end else begin
            ilkEnQ <= wIlk ? (ilkEnQ & ~wMask[NUM_PRE-1:0]) | wMerge[NUM_PRE-1:0] : ilkEnQ;
            progQ <= wProg ? (progQ & ~wMask[NUM_PRE-1:0]) | wMerge[NUM_PRE-1:0] : progQ;
            y2gEnQ <= wY2g ? (y2gNew & ~termAllQ) : y2gEnQ;
            termAllQ <= wTerm ? (termNew & ~y2gEnQ) : termAllQ;
            modeQ <= wMode ? (modeQ & ~wMask[NUM_PRE*MODE_W-1:0]) | wMerge[NUM_PRE*MODE_W-1:0] : modeQ;
            // A new event wins over a clear in the same cycle.
            intStQ <= (intStQ & ~istClr) | evt;
            intMaskQ <= wImask ? (intMaskQ & ~wMask[NUM_EVT-1:0]) | wMerge[NUM_EVT-1:0] : intMaskQ;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= RST_CFG;
        end else begin
            bvalid <= wrGo ? 1'b1 : (bready ? 1'b0 : bvalid);
            bresp <= wrGo ? (wHit ? RESP_OKAY : RESP_SLVERR) : bresp;
            rvalid <= rdGo ? 1'b1 : (rready ? 1'b0 : rvalid);
            rresp <= rdGo ? (rHit ? RESP_OKAY : RESP_SLVERR) : rresp;
            rdata <= rdGo ? rdMux : rdata;
        end
    end

    // ----------------------------------------------------------------
    // Yellow clearance revert at preemption entry
    // ----------------------------------------------------------------
    wire logic planOk = (entryPlan < 4'(NUM_PRE));
    wire logic planY2g = planOk && y2gEnQ[entryPlan];
    wire logic [NUM_PHASE-1:0] y2gGrant =
        yellowPhases & nextGreenPhases & {NUM_PHASE{planY2g && !lagOvlpGreen}};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            yellowToGreen <= '0;
            redRevert <= '0;
        end else begin
            yellowToGreen <= entryCall ? y2gGrant : '0;
            redRevert <= entryCall ? (yellowPhases & ~y2gGrant) : '0;
        end
    end

    // ----------------------------------------------------------------
    // Interlock monitors
    // ----------------------------------------------------------------
    // Preempts 1 and 2 both watch interlock input 1; interlock input 2 stays unread.
    for (genvar i = 0; i < NUM_PRE; i++) begin : gMon
        localparam int IDX = (i == 1) ? 0 : i;
        pei_ilk_timer #(.SETTLE_C(SETTLE_C), .FAULT_C(FAULT_C)) uTimer (
            .clk(clk),
            .rst_b(rst_b),
            .monEn(ilkEnQ[i] && progQ[i]),
            .preemptLvl(preSyncQ[i]),
            .interlockLvl(ilkSyncQ[IDX]),
            .trip(tripVec[i])
        );
    end

    // ----------------------------------------------------------------
    // Fault sequence to latched flash
    // ----------------------------------------------------------------
    wire logic anyTrip = |tripVec;
    wire logic anyTerm = |preemptTerm;
    wire logic p1After = preemptActive[0] && trackClrDone[0];
    wire logic p2After = preemptActive[1] && trackClrDone[1];
    wire logic directRed = !anyTerm && (p1After || (p2After && !progQ[0]));

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            FLT_IDLE: begin
                if (anyTrip) begin
                    stateD = directRed ? FLT_ALLRED : FLT_FORCE;
                end
            end
            FLT_FORCE: begin
                if (|trackClrDone) begin
                    stateD = FLT_ALLRED;
                end
            end
            FLT_ALLRED: begin
                if (allRedDone) begin
                    stateD = FLT_LATCHED;
                end
            end
            FLT_LATCHED: begin
                if (latchClr) begin
                    stateD = FLT_IDLE;
                end
            end
            default: begin
                stateD = FLT_IDLE;
            end
        endcase
    end

    wire logic enterForce = (stateQ == FLT_IDLE) && (stateD == FLT_FORCE);
    wire logic viaForceD = (stateD == FLT_IDLE) ? 1'b0 : (viaForceQ || enterForce);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateQ <= FLT_IDLE;
            viaForceQ <= 1'b0;
            forcePreempt <= 2'h0;
            restartPreempt <= 2'h0;
            allRedReq <= 1'b0;
            faultMonOk <= 1'b1;
        end else begin
            stateQ <= stateD;
            viaForceQ <= viaForceD;
            forcePreempt <= {2{viaForceD}};
            restartPreempt <= (enterForce && anyTerm) ? preemptActive[1:0] : 2'h0;
            allRedReq <= (stateD == FLT_ALLRED) || (stateD == FLT_LATCHED);
            faultMonOk <= (stateD != FLT_LATCHED);
        end
    end

    assign evt[EVT_FAULT] = (stateQ == FLT_IDLE) && anyTrip;
    assign evt[EVT_REFUSE] = |(y2gRefused | termRefused);
    assign evt[EVT_Y2G] = entryCall && (|y2gGrant);

    // ----------------------------------------------------------------
    // Active status outputs
    // ----------------------------------------------------------------
    logic flashSlowRate;
    logic flashMediumRate;
    logic flashFastRate;

    pei_flash_gen #(.HALF_CYC(SLOW_C)) uSlow (.clk(clk), .rst_b(rst_b), .wave(flashSlowRate));
    pei_flash_gen #(.HALF_CYC(MED_C)) uMed (.clk(clk), .rst_b(rst_b), .wave(flashMediumRate));
    pei_flash_gen #(.HALF_CYC(FAST_C)) uFast (.clk(clk), .rst_b(rst_b), .wave(flashFastRate));

    for (genvar i = 0; i < NUM_PRE; i++) begin : gStat
        wire logic [MODE_W-1:0] md = modeQ[i*MODE_W +: MODE_W];
        wire logic pattern = (md == STAT_SOLID) || ((md == STAT_SLOW) && flashSlowRate)
            || ((md == STAT_MED) && flashMediumRate) || ((md == STAT_FAST) && flashFastRate);
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                activeStatus[i] <= 1'b0;
            end else begin
                activeStatus[i] <= progQ[i] && preemptActive[i] && pattern;
            end
        end
        statusOff_a: assert property (@(posedge clk) disable iff (!rst_b)
            !$past(progQ[i]) || ($past(md) == STAT_OFF) |-> !activeStatus[i])
            else $error("Status output on while preemptor disabled or off.");
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    optConflict_a: assert property (@(posedge clk) disable iff (!rst_b)
        (y2gEnQ & termAllQ) == '0)
        else $error("Yellow-to-green and terminate-all both enabled.");
    y2gGrant_a: assert property (@(posedge clk) disable iff (!rst_b)
        entryCall && planY2g && !lagOvlpGreen |=> yellowToGreen == $past(yellowPhases & nextGreenPhases))
        else $error("Yellow phase not returned to green.");
    ovlpSuppress_a: assert property (@(posedge clk) disable iff (!rst_b)
        entryCall && lagOvlpGreen |=> yellowToGreen == '0 && redRevert == $past(yellowPhases))
        else $error("Revert not suppressed by lagging overlap.");
    redRevert_a: assert property (@(posedge clk) disable iff (!rst_b)
        entryCall && !planY2g |=> redRevert == $past(yellowPhases) && yellowToGreen == '0)
        else $error("Yellow phase skipped red revert.");
    forceBoth_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateQ == FLT_IDLE && anyTrip && !anyTerm && preemptActive[1:0] == 2'h0
        |=> forcePreempt == 2'h3 && faultMonOk ##1 forcePreempt == 2'h3)
        else $error("Both preemptors not forced on idle fault.");
    directRed_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateQ == FLT_IDLE && anyTrip && !anyTerm && p1After |=> allRedReq && forcePreempt == 2'h0)
        else $error("Active preemptor 1 fault not cleared straight to red.");
    restart_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateQ == FLT_IDLE && anyTrip && anyTerm |=> restartPreempt == $past(preemptActive[1:0])
        ##1 restartPreempt == 2'h0)
        else $error("Terminating fault did not restart preemptors.");
    latchHold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !faultMonOk && !latchClr |=> !faultMonOk && allRedReq)
        else $error("Latched flash released without clear.");
    flashEntry_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateQ == FLT_ALLRED && allRedDone |=> !faultMonOk)
        else $error("Monitor not forced false after all red.");
endmodule

/* File: common/pei_pkg.sv */
// Shared constants and types for the preempt entry interlock block.
package pei_pkg;
    localparam int NUM_PRE = 10;
    localparam int NUM_PHASE = 8;
    localparam int NUM_EVT = 3;
    localparam int ADDR_W = 6;
    localparam int MODE_W = 3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int SETTLE_MS = 3000;
    localparam int FAULT_MS = 1000;
    localparam int SLOW_HALF_MS = 500;
    localparam int MED_HALF_MS = 200;
    localparam int FAST_HALF_MS = 100;
    localparam int SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
    localparam int FAULT_CYC = FAULT_MS * CYC_PER_MS;
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
    localparam int MED_HALF_CYC = MED_HALF_MS * CYC_PER_MS;
    localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_ILK_EN = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_PROG = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_Y2G = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TERM_ALL = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_MODE = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_FAULT = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_LATCH_CLR = 6'h20;
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam int EVT_FAULT = 0;
    localparam int EVT_REFUSE = 1;
    localparam int EVT_Y2G = 2;
    localparam int FLT_LATCH_BIT = 0;
    localparam int FLT_ALLRED_BIT = 1;
    localparam int FLT_FORCE_BIT = 2;
    localparam int FLT_TRIP_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [MODE_W-1:0] {STAT_OFF, STAT_SOLID, STAT_SLOW, STAT_MED, STAT_FAST} pei_mode_t;
    typedef enum logic [1:0] {FLT_IDLE, FLT_FORCE, FLT_ALLRED, FLT_LATCHED} pei_flt_state_t;
endpackage

/* File: src/pei_flash_gen.sv */
// Square wave generator for one status flash rate.
`timescale 1ns/1ps
module pei_flash_gen import pei_pkg::*; #(
    parameter int HALF_CYC = SLOW_HALF_CYC
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Synchronous reset, active low.
    output logic wave // Flash waveform, toggles every half period.
);
    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] cntQ;
    wire logic wrap = (cntQ == CW'(HALF_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cntQ <= '0;
            wave <= 1'b0;
        end else begin
            cntQ <= wrap ? '0 : cntQ + 1'b1;
            wave <= wrap ? ~wave : wave;
        end
    end
endmodule

/* File: src/pei_ilk_timer.sv */
// Settle and persistence timer for one preempt and interlock input pair.
`timescale 1ns/1ps
module pei_ilk_timer import pei_pkg::*; #(
    parameter int SETTLE_C = SETTLE_CYC,
    parameter int FAULT_C = FAULT_CYC
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic monEn, // Interlock enabled and preemptor programmed.
    input wire logic preemptLvl, // Synchronised preempt input, high when active.
    input wire logic interlockLvl, // Synchronised interlock input, high when true.
    output logic trip // Inputs not opposite for the full fault time.
);
    localparam int CW = $clog2((SETTLE_C > FAULT_C ? SETTLE_C : FAULT_C) + 1);
    logic prePrevQ;
    logic ilkPrevQ;
    logic [CW-1:0] settleQ;
    logic [CW-1:0] failQ;
    wire logic changed = (preemptLvl != prePrevQ) || (interlockLvl != ilkPrevQ);
    wire logic settled = (settleQ == '0);
    // Inactive preempt wants a true interlock, so equal levels mean a fault.
    wire logic mismatch = monEn && settled && (preemptLvl == interlockLvl);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prePrevQ <= 1'b0;
            ilkPrevQ <= 1'b0;
            settleQ <= CW'(SETTLE_C);
            failQ <= '0;
        end else begin
            prePrevQ <= preemptLvl;
            ilkPrevQ <= interlockLvl;
            if (changed || !monEn) begin
                settleQ <= CW'(SETTLE_C);
            end else if (!settled) begin
                settleQ <= settleQ - 1'b1;
            end
            if (!mismatch) begin
                failQ <= '0;
            end else if (failQ != CW'(FAULT_C)) begin
                failQ <= failQ + 1'b1;
            end
        end
    end

    assign trip = (failQ == CW'(FAULT_C));

    tripCause_a: assert property (@(posedge clk) disable iff (!rst_b)
        trip |-> $past(settleQ) == '0 && $past(monEn) && $past(preemptLvl) == $past(interlockLvl))
        else $error("Interlock trip without settled mismatch.");
endmodule

/* File: verification/pei_pin_model.sv */
// Model of the hard-wired preempt and interlock pin circuits.
`timescale 1ns/1ps
module pei_pin_model import pei_pkg::*; (
    input wire logic clk, // System clock.
    input wire logic breakPair, // Drive pair one equal instead of opposite.
    output logic [NUM_PRE-1:0] preemptIn, // Preempt pins, all idle.
    output logic [NUM_PRE-1:0] interlockIn // Interlock pins.
);
    // Pin two sits where it would trip preemptor two at once if anything read it.
    always_ff @(posedge clk) begin
        preemptIn <= '0;
        interlockIn <= {8'hFF, 1'b0, ~breakPair};
    end
endmodule

/* File: verification/preempt_entry_interlock_bench.sv */
// Self-checking bench for the preempt entry interlock block.
`timescale 1ns/1ps
module preempt_entry_interlock_bench import pei_pkg::*; ();
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, entryPlan;
    logic [1:0] bresp, rresp, trackClrDone, forcePreempt, rp;
    logic [NUM_PRE-1:0] preemptIn, interlockIn, activeStatus, pa, pt;
    logic [7:0] yellowPhases, nextGreenPhases, yellowToGreen, redRevert, rs, g;
    logic entryCall, lagOvlpGreen, allRedDone, allRedReq, faultMonOk, irq, breakPair;
    logic [33:0] q[$];
    int errorCnt = 0, checks = 0, i, k;
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    pei_pin_model u_pins (.clk(clk), .breakPair(breakPair), .preemptIn(preemptIn), .interlockIn(interlockIn));
    pei_top #(.SETTLE_C(20), .FAULT_C(10), .SLOW_C(10), .MED_C(4), .FAST_C(2)) u_dut (.clk(clk), .rst_b(rst_b),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .preemptIn(preemptIn), .interlockIn(interlockIn), .preemptActive(pa), .preemptTerm(pt),
        .trackClrTiming(~trackClrDone), .trackClrDone(trackClrDone), .allRedDone(allRedDone), .entryCall(entryCall),
        .entryPlan(entryPlan), .yellowPhases(yellowPhases), .nextGreenPhases(nextGreenPhases),
        .lagOvlpGreen(lagOvlpGreen), .yellowToGreen(yellowToGreen), .redRevert(redRevert),
        .forcePreempt(forcePreempt), .restartPreempt(rp), .allRedReq(allRedReq), .faultMonOk(faultMonOk),
        .activeStatus(activeStatus), .irq(irq));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lf(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic endSim;
        $display("Checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        checks++;
        if (s !== e) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1) @(posedge clk);
        chk("bresp", RESP_OKAY, bresp);
        bready <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] e);
        q.push_back(e); araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 0;
        @(posedge clk);
    endtask
    always @(posedge clk) if (rvalid === 1'b1 && rready === 1'b1) chk("read", q.pop_front(), {rresp, rdata});
    initial begin
        #100us;
        errorCnt++;
        endSim;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, entryCall, lagOvlpGreen, allRedDone, breakPair, rst_b} = '0;
        {awaddr, araddr, wdata, wstrb, entryPlan, yellowPhases, nextGreenPhases, trackClrDone, pa, pt} = '0;
        rs = 8'h29;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        rd(OFF_MODE, {RESP_OKAY, RST_CFG});
        rd(6'h3C, {RESP_SLVERR, 32'h0000_0000});
        wr(OFF_TERM_ALL, 32'h0000_0002);
        wr(OFF_Y2G, 32'h0000_0003);
        rd(OFF_Y2G, {RESP_OKAY, 32'h0000_0001});
        for (k = 0; k < 4; k++) begin
            rs = lf(rs);
            entryCall <= 1; entryPlan <= 4'(k % 2); lagOvlpGreen <= k[1];
            yellowPhases <= rs | 8'h01; nextGreenPhases <= lf(rs) | 8'h01;
            @(posedge clk);
            entryCall <= 0;
            #1 g = yellowPhases & nextGreenPhases & {8{k == 0}};
            chk("yellowToGreen", g, yellowToGreen);
            chk("redRevert", yellowPhases & ~g, redRevert);
        end
        wr(OFF_INT_MASK, 32'h0000_0001); wr(OFF_PROG, 32'h0000_0003); wr(OFF_ILK_EN, 32'h0000_0003);
        repeat (40) @(posedge clk);
        chk("forcePreempt", 0, forcePreempt);
        breakPair <= 1;
        for (i = 0; i < 200 && forcePreempt !== 2'b11; i++) @(posedge clk);
        chk("forcePreempt", 2'b11, forcePreempt);
        chk("settleWait", 1, i >= 30);
        trackClrDone <= 2'b01;
        for (i = 0; i < 50 && allRedReq !== 1'b1; i++) @(posedge clk);
        chk("allRedReq", 1, allRedReq);
        allRedDone <= 1;
        for (i = 0; i < 50 && faultMonOk !== 1'b0; i++) @(posedge clk);
        chk("faultMonOk", 0, faultMonOk);
        chk("irq", 1, irq);
        {breakPair, allRedDone, trackClrDone} <= '0;
        repeat (40) @(posedge clk);
        chk("faultMonOk", 0, faultMonOk);
        rd(OFF_INT_STAT, {RESP_OKAY, 32'h0000_0007});
        wr(OFF_LATCH_CLR, 32'h0000_0001); wr(OFF_INT_STAT, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chk("faultMonOk", 1, faultMonOk);
        chk("irq", 0, irq);
        wr(OFF_MODE, 32'h0000_0001); pa <= 10'h001; pt <= 10'h004;
        repeat (2) @(posedge clk);
        chk("activeStatus", 10'h001, activeStatus);
        breakPair <= 1;
        for (i = 0; i < 200 && rp !== 2'b01; i++) @(posedge clk);
        chk("restartPreempt", 2'b01, rp);
        endSim;
    end
endmodule
